/* File: asq_pkg.sv */
// Functional notes
// - command byte write starts first selected conversion
// - next conversion runs while result is read
// - host nack ends transmit, then stop
// - host uses repeated start after command write
// - command write restores pointer; reads trigger next
// - result is flag, channel, four msbs, eight lsbs
// - after last selected channel wrap to first
// - command byte is a channel bitmask
// - command mode ends after 5 ms without read
// - autocycle converts every 50 us, result latest
// - autocycle off at reset, config bit 12 enables
// - host disables autocycle before command mode
// - host stops command mode before re-enabling autocycle
// - host masks temperature alarms 500 ms after switch
// - result flag set when any channel violates limits
// - voltage status holds high/low bits per input
// - status bits are sticky and accumulate
// - current status holds limits plus overrange bits
// - host clears overrange bits after power-up
// - temperature status holds diode, overtemp, limit bits
// - writing ones clears status bits
// - config bits 1 and 2 clear all, enable alert
package asq_pkg;

  // ----------------------------------------------------------------
  // register pointers and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_CMD = 8'h00;
  localparam logic [7:0] PTR_RESULT = 8'h01;
  localparam logic [7:0] PTR_ALERT_V = 8'h05;
  localparam logic [7:0] PTR_ALERT_I = 8'h06;
  localparam logic [7:0] PTR_ALERT_T = 8'h07;
  localparam logic [7:0] PTR_SEQ = 8'h08;
  localparam logic [7:0] PTR_CFG = 8'h09;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int CFG_AUTO_BIT = 12;
  localparam int CFG_CLR_A_BIT = 1;
  localparam int CFG_CLR_B_BIT = 2;
  localparam logic [4:0] ALR_OVR_LSB = 5'h0C;
  localparam logic [4:0] ALR_OTEMP = 5'h16;
  localparam logic [4:0] ALR_DIODE = 5'h17;
  localparam logic [4:0] ALR_TEMP_OFS = 5'h04;
  localparam logic [2:0] CHAN_FIRST_TEMP = 3'h6;
  localparam logic [2:0] CHAN_LAST = 3'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 50000;
  localparam int CMD_TIMEOUT_MS = 5;
  localparam int AUTO_PERIOD_US = 50;
  localparam int TMO_CYC = CMD_TIMEOUT_MS * CLK_KHZ;
  localparam int AUTO_CYC = AUTO_PERIOD_US * CLK_KHZ / 1000;
  localparam int TMO_W = 18;
  localparam int AUTO_W = 12;

  // ----------------------------------------------------------------
  // host command port
  // ----------------------------------------------------------------
  localparam logic [1:0] HREG_CMD = 2'h0;
  localparam logic [1:0] HREG_DATA = 2'h1;
  localparam logic [1:0] HREG_STAT = 2'h2;
  localparam int HC_START = 0;
  localparam int HC_STOP = 1;
  localparam int HC_WRITE = 2;
  localparam int HC_READ = 3;
  localparam int HC_NACK = 4;

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_RX = 3'b001,
    DS_RXACK = 3'b010,
    DS_TX = 3'b011,
    DS_TXACK = 3'b100
  } asq_dstate_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BITS = 2'b10,
    HS_STOP = 2'b11
  } asq_hstate_t;

endpackage : asq_pkg

/* File: asq_link_if.sv */
// two-wire link: host makes the clock, data line is open drain
interface asq_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // wired-and of both drivers, pulled up when nobody drives
  assign sda = (host_sda_oe ? host_sda_o : 1'b1)
             & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, output host_sda_o, output host_sda_oe,
                input sda);
endinterface : asq_link_if

/* File: asq_dev.sv */
module asq_dev
  import asq_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h61,
  parameter int TIMEOUT_CYC = TMO_CYC
) (
  // link
  asq_link_if.dev link,
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // converter
  output logic o_conv_start,
  output logic [2:0] o_conv_chan,
  input wire logic i_conv_done,
  input wire logic [11:0] i_conv_data,
  input wire logic i_conv_over_high,
  input wire logic i_conv_under_low,
  // fault events
  input wire logic [1:0] i_overrange,
  input wire logic i_diode_open,
  input wire logic i_overtemp,
  // status
  output logic o_cmd_mode,
  output logic o_auto_active,
  output logic o_alert,
  output logic o_dac_hiz
);

  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << TMO_W)) begin : g_chk
    $error("TIMEOUT_CYC out of range");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;
  asq_dstate_t st_r;
  logic [3:0] bit_r;
  logic [7:0] sr_r, ptr_r, ptr_save_r, hold_r, tx_byte, res_lo_r;
  logic first_r, rw_r, ack_r, lo_r, is16, load_tx;
  logic [1:0] wph_r;
  logic wr_r, rd_r, stop_r;
  logic [7:0] wr_addr_r;
  logic [15:0] wr_val_r;
  logic [15:0] cfg_r, result_r;
  logic [7:0] seq_r, mask_r;
  logic cmd_r, cmd_wr, tmo_hit, auto_on, auto_tick;
  logic [TMO_W-1:0] tmo_r;
  logic [AUTO_W-1:0] auto_r;
  logic pend_r, busy_r, conv_req, go, conv_end;
  logic [2:0] pch_r, chan_r, req_ch;
  logic [23:0] alerts_r, set_v, clr_v;
  logic [4:0] slot;
  logic alert_en_r, alert_r;

  // next selected channel after cur, ascending with wrap
  function automatic logic [2:0] next_chan(input logic [7:0] m,
                                           input logic [2:0] cur);
    logic [2:0] idx;
    logic found;
    next_chan = cur;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      idx = cur + 3'(i);
      if (!found && m[idx]) begin
        next_chan = idx;
        found = 1'b1;
      end
    end
  endfunction : next_chan

  // ----------------------------------------------------------------
  // link sampling
  // ----------------------------------------------------------------
  // the bus pins are asynchronous; edges compare the second stage with the third
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  assign is16 = (ptr_r == PTR_RESULT) || (ptr_r == PTR_CFG);

  always_comb begin
    tx_byte = 8'h00;
    case (ptr_r)
      PTR_RESULT: tx_byte = lo_r ? res_lo_r : result_r[15:8];
      PTR_CMD: tx_byte = mask_r;
      PTR_ALERT_V: tx_byte = alerts_r[7:0];
      PTR_ALERT_I: tx_byte = alerts_r[15:8];
      PTR_ALERT_T: tx_byte = alerts_r[23:16];
      PTR_SEQ: tx_byte = seq_r;
      PTR_CFG: tx_byte = lo_r ? cfg_r[7:0] : cfg_r[15:8];
      default: tx_byte = 8'h00;
    endcase
  end

  assign load_tx = scl_fall && (((st_r == DS_RXACK) && rw_r) ||
                                ((st_r == DS_TXACK) && ack_r));

  // ----------------------------------------------------------------
  // byte engine of the slave
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= DS_IDLE;
      bit_r <= 4'h0;
      sr_r <= 8'h00;
      first_r <= 1'b0;
      rw_r <= 1'b0;
      ack_r <= 1'b0;
      lo_r <= 1'b0;
      wph_r <= 2'h0;
      ptr_r <= PTR_RESET;
      ptr_save_r <= PTR_RESET;
      hold_r <= 8'h00;
      res_lo_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      stop_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_val_r <= 16'h0000;
    end else begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      stop_r <= 1'b0;
      if (start_det) begin
        // a repeated start keeps command mode alive
        st_r <= DS_RX;
        bit_r <= 4'h0;
        first_r <= 1'b1;
        wph_r <= 2'h0;
        lo_r <= 1'b0;
      end else if (stop_det) begin
        st_r <= DS_IDLE;
        stop_r <= 1'b1;
      end else begin
        unique case (st_r)
          DS_IDLE: ;
          DS_RX: begin
            if (scl_rise) begin
              sr_r <= {sr_r[6:0], sda_s2};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == BYTE_BITS) begin
              st_r <= DS_RXACK;
              if (first_r) begin
                first_r <= 1'b0;
                rw_r <= sr_r[0];
                if (sr_r[7:1] != DEV_ADDR) st_r <= DS_IDLE;
              end else begin
                unique case (wph_r)
                  2'h0: begin
                    ptr_r <= sr_r;
                    wph_r <= 2'h1;
                    if (sr_r == PTR_CMD) ptr_save_r <= ptr_r;
                  end
                  2'h1: begin
                    if (is16) begin
                      hold_r <= sr_r;
                      wph_r <= 2'h2;
                    end else begin
                      wr_r <= 1'b1;
                      wr_addr_r <= ptr_r;
                      wr_val_r <= {8'h00, sr_r};
                      wph_r <= 2'h0;
                      if (ptr_r == PTR_CMD) ptr_r <= ptr_save_r;
                    end
                  end
                  default: begin
                    wr_r <= 1'b1;
                    wr_addr_r <= ptr_r;
                    wr_val_r <= {hold_r, sr_r};
                    wph_r <= 2'h0;
                  end
                endcase
              end
            end
          end
          DS_RXACK: begin
            if (scl_fall) begin
              st_r <= DS_RX;
              bit_r <= 4'h0;
            end
          end
          DS_TX: begin
            if (scl_fall) begin
              if (bit_r == 4'h7) begin
                st_r <= DS_TXACK;
              end else begin
                sr_r <= {sr_r[6:0], 1'b0};
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          DS_TXACK: begin
            if (scl_rise) ack_r <= ~sda_s2;
            else if (scl_fall) st_r <= DS_IDLE;
          end
          default: st_r <= DS_IDLE;
        endcase
        if (load_tx) begin
          st_r <= DS_TX;
          bit_r <= 4'h0;
          sr_r <= tx_byte;
          lo_r <= is16 & ~lo_r;
          // freeze the low byte now: the overlapping conversion lands
          // before it is sent and would otherwise split the result
          if (!lo_r) res_lo_r <= result_r[7:0];
          rd_r <= (ptr_r == PTR_RESULT) && !lo_r;
        end
      end
    end
  end

  // open drain: enable pulls low for ack and for zero data bits
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = (st_r == DS_RXACK) ||
                           ((st_r == DS_TX) && !sr_r[7]);

  // ----------------------------------------------------------------
  // configuration and mode
  // ----------------------------------------------------------------
  assign cmd_wr = wr_r && (wr_addr_r == PTR_CMD);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_r <= 16'h0000;
      seq_r <= 8'h00;
    end else if (wr_r && wr_addr_r == PTR_CFG) begin
      cfg_r <= wr_val_r;
    end else if (wr_r && wr_addr_r == PTR_SEQ) begin
      seq_r <= wr_val_r[7:0];
    end
  end

  // stop or timeout ends command mode; a new sequence needs a new write
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd_r <= 1'b0;
      mask_r <= 8'h00;
    end else if (cmd_wr) begin
      cmd_r <= |wr_val_r[7:0];
      mask_r <= wr_val_r[7:0];
    end else if (stop_r || tmo_hit) begin
      cmd_r <= 1'b0;
    end
  end

  // silence watchdog, restarted by each result read
  always_ff @(posedge i_clk) begin
    if (i_rst || !cmd_r || rd_r || cmd_wr) tmo_r <= '0;
    else tmo_r <= tmo_r + TMO_W'(1);
  end
  assign tmo_hit = cmd_r && (tmo_r == TMO_W'(TIMEOUT_CYC - 1));

  // background pacing, held off by command mode or an empty sequence
  assign auto_on = cfg_r[CFG_AUTO_BIT] && (|seq_r) && !cmd_r;
  assign auto_tick = auto_on && (auto_r == AUTO_W'(AUTO_CYC - 1));
  always_ff @(posedge i_clk) begin
    if (i_rst || !auto_on || auto_tick) auto_r <= '0;
    else auto_r <= auto_r + AUTO_W'(1);
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_comb begin
    conv_req = 1'b0;
    req_ch = chan_r;
    if (cmd_wr && (|wr_val_r[7:0])) begin
      conv_req = 1'b1;
      req_ch = next_chan(wr_val_r[7:0], CHAN_LAST);
    end else if (rd_r && cmd_r) begin
      conv_req = 1'b1;
      req_ch = next_chan(mask_r, chan_r);
    end else if (auto_tick) begin
      conv_req = 1'b1;
      req_ch = next_chan(seq_r, chan_r);
    end
  end

  // a request arriving while busy waits; a newer one replaces it
  assign go = pend_r && !busy_r;
  assign conv_end = busy_r && i_conv_done;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_r <= 1'b0;
      pch_r <= 3'h0;
      busy_r <= 1'b0;
      chan_r <= CHAN_LAST;
    end else begin
      if (conv_req) begin
        pend_r <= 1'b1;
        pch_r <= req_ch;
      end else if (go) begin
        pend_r <= 1'b0;
      end
      if (go) begin
        busy_r <= 1'b1;
        chan_r <= pch_r;
      end else if (i_conv_done) begin
        busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) result_r <= 16'h0000;
    else if (conv_end)
      result_r <= {i_conv_over_high | i_conv_under_low | (|alerts_r),
                   chan_r, i_conv_data};
  end

  // ----------------------------------------------------------------
  // alert status
  // ----------------------------------------------------------------
  // voltage slots 0-3, current 4-5, temperature skips the overrange bits
  assign slot = (chan_r < CHAN_FIRST_TEMP) ? {1'b0, chan_r, 1'b0}
                : ({1'b0, chan_r, 1'b0} + ALR_TEMP_OFS);

  always_comb begin
    set_v = 24'h000000;
    if (conv_end) begin
      set_v[slot] = i_conv_under_low;
      set_v[slot + 5'h01] = i_conv_over_high;
    end
    set_v[ALR_OVR_LSB] = i_overrange[0];
    set_v[ALR_OVR_LSB + 5'h01] = i_overrange[1];
    set_v[ALR_OTEMP] = i_overtemp;
    set_v[ALR_DIODE] = i_diode_open;
  end

  always_comb begin
    clr_v = 24'h000000;
    if (wr_r) begin
      unique case (wr_addr_r)
        PTR_ALERT_V: clr_v[7:0] = wr_val_r[7:0];
        PTR_ALERT_I: clr_v[15:8] = wr_val_r[7:0];
        PTR_ALERT_T: clr_v[23:16] = wr_val_r[7:0];
        PTR_CFG: if (wr_val_r[CFG_CLR_A_BIT] && wr_val_r[CFG_CLR_B_BIT])
          clr_v = 24'hFFFFFF;
        default: ;
      endcase
    end
  end

  // set beats a clear in the same cycle so no event is lost
  always_ff @(posedge i_clk) begin
    if (i_rst) alerts_r <= 24'h000000;
    else alerts_r <= (alerts_r & ~clr_v) | set_v;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alert_en_r <= 1'b0;
      alert_r <= 1'b0;
    end else begin
      if (clr_v == 24'hFFFFFF && wr_addr_r == PTR_CFG) alert_en_r <= 1'b1;
      alert_r <= alert_en_r && (|alerts_r);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_conv_start = go;
  assign o_conv_chan = pch_r;
  assign o_cmd_mode = cmd_r;
  assign o_auto_active = auto_on;
  assign o_alert = alert_r;
  assign o_dac_hiz = alerts_r[ALR_OTEMP];

endmodule : asq_dev

/* File: asq_host.sv */
module asq_host
  import asq_pkg::*;
#(
  parameter int QUARTER = 4
) (
  // link
  asq_link_if.host link,
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // software port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_busy
);

  // the slave needs about four cycles to react to a clock edge
  if (QUARTER < 4 || QUARTER > 255) begin : g_chk
    $error("QUARTER out of range");
  end

  asq_hstate_t st_r;
  logic scl_r, oe_r, rdm_r, nack_r, ack_r, tick;
  logic sda_s1, sda_s2;
  logic [7:0] div_r, tx_r, rx_r, rdata_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;

  // ----------------------------------------------------------------
  // data line sampling
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  assign tick = (div_r == 8'(QUARTER - 1));

  // ----------------------------------------------------------------
  // bit engine: each op walks four quarter phases per bit
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= HS_IDLE;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      div_r <= 8'h00;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rdm_r <= 1'b0;
      nack_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (st_r == HS_IDLE) begin
      div_r <= 8'h00;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      if (i_wr && i_addr == HREG_DATA) tx_r <= i_wdata;
      if (i_wr && i_addr == HREG_CMD) begin
        nack_r <= i_wdata[HC_NACK];
        rdm_r <= i_wdata[HC_READ] && !i_wdata[HC_WRITE];
        if (i_wdata[HC_START]) st_r <= HS_START;
        else if (i_wdata[HC_WRITE] || i_wdata[HC_READ]) st_r <= HS_BITS;
        else if (i_wdata[HC_STOP]) st_r <= HS_STOP;
      end
    end else begin
      div_r <= tick ? 8'h00 : div_r + 8'h01;
      if (tick) begin
        ph_r <= ph_r + 2'h1;
        unique case (st_r)
          HS_START: begin
            unique case (ph_r)
              2'h0: oe_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: oe_r <= 1'b1;
              2'h3: begin
                scl_r <= 1'b0;
                st_r <= HS_IDLE;
              end
            endcase
          end
          HS_STOP: begin
            unique case (ph_r)
              2'h0: oe_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: oe_r <= 1'b0;
              2'h3: st_r <= HS_IDLE;
            endcase
          end
          HS_BITS: begin
            unique case (ph_r)
              2'h0: oe_r <= rdm_r ? (bit_r == BYTE_BITS && !nack_r)
                                  : (bit_r != BYTE_BITS && !tx_r[7]);
              2'h1: scl_r <= 1'b1;
              2'h2: begin
                if (rdm_r && bit_r != BYTE_BITS) rx_r <= {rx_r[6:0], sda_s2};
                if (!rdm_r && bit_r == BYTE_BITS) ack_r <= !sda_s2;
              end
              2'h3: begin
                scl_r <= 1'b0;
                if (bit_r == BYTE_BITS) begin
                  oe_r <= 1'b0;
                  st_r <= HS_IDLE;
                end else begin
                  bit_r <= bit_r + 4'h1;
                  if (!rdm_r) tx_r <= {tx_r[6:0], 1'b0};
                end
              end
            endcase
          end
          default: st_r <= HS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // software read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        HREG_STAT: rdata_r <= {6'h00, ack_r, st_r != HS_IDLE};
        HREG_DATA: rdata_r <= rx_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign o_rdata = rdata_r;
  assign o_busy = (st_r != HS_IDLE);
  assign link.scl = scl_r;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe_r;

endmodule : asq_host

/* File: asq_link_sva.sv */
module asq_link_sva (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link wires
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // wire checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wired_and_a: assert property (sda == !(host_sda_oe || dev_sda_oe))
    else $error("data line level wrong");
  dev_low_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data high");
  host_low_a: assert property (host_sda_oe |-> !host_sda_o)
    else $error("host drives data high");
  // device may only move data while the clock is low
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data moved with clock high");
  drive_clash_a: assert property (!(scl && host_sda_oe && dev_sda_oe))
    else $error("both ends drive data");
  scl_phase_a: assert property ($changed(scl) |=> $stable(scl) [*3])
    else $error("clock phase too short");
  start_hold_a: assert property ($fell(sda) && scl |=> scl [*3])
    else $error("clock fell too soon after start");
  // reset is not a disable here: the released state is what is checked
  rst_idle_a: assert property (disable iff (1'b0) $past(i_rst) && !i_rst |->
    scl && !host_sda_oe && !dev_sda_oe)
    else $error("link not idle after reset");
  cover property ($fell(sda) && scl);
  cover property (dev_sda_oe && $rose(scl));
  cover property ($rose(sda) && scl);
endmodule : asq_link_sva

/* File: tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import asq_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata, b;
  logic o_busy, o_conv_start, o_cmd_mode, o_auto_active, o_alert, o_dac_hiz;
  logic [2:0] o_conv_chan, ch_r;
  logic i_conv_done = 1'b0;
  logic [11:0] i_conv_data = 12'h000;
  logic [1:0] i_ovr = 2'h0;
  logic i_diode = 1'b0;
  logic i_otemp = 1'b0;
  logic hi = 1'b0;
  logic [11:0] last_d [8];
  logic [31:0] seed = 32'h48212C85;
  int cnt = 0;
  int n;
  int n_fail = 0;
  int samples_checked = 0;
  asq_link_if u_asq_link_if ();
  asq_host u_asq_host (.link(u_asq_link_if), .i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_busy(o_busy));
  // short timeout keeps the idle wait affordable
  asq_dev #(.TIMEOUT_CYC(2000)) u_asq_dev (.link(u_asq_link_if),
    .i_clk(i_clk), .i_rst(i_rst), .o_conv_start(o_conv_start),
    .o_conv_chan(o_conv_chan), .i_conv_done(i_conv_done),
    .i_conv_data(i_conv_data), .i_conv_over_high(hi),
    .i_conv_under_low(1'b0), .i_overrange(i_ovr), .i_diode_open(i_diode),
    .i_overtemp(i_otemp), .o_cmd_mode(o_cmd_mode),
    .o_auto_active(o_auto_active), .o_alert(o_alert), .o_dac_hiz(o_dac_hiz));
  asq_link_sva u_asq_link_sva (.i_clk(i_clk), .i_rst(i_rst),
    .scl(u_asq_link_if.scl), .host_sda_o(u_asq_link_if.host_sda_o),
    .host_sda_oe(u_asq_link_if.host_sda_oe),
    .dev_sda_o(u_asq_link_if.dev_sda_o),
    .dev_sda_oe(u_asq_link_if.dev_sda_oe), .sda(u_asq_link_if.sda));
  initial forever #10 i_clk = ~i_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // converter: random result 20 cycles after each start
  always @(posedge i_clk) begin
    seed <= lfsr(seed);
    i_conv_done <= (cnt == 1);
    if (cnt == 1) begin
      i_conv_data <= seed[11:0];
      last_d[ch_r] <= seed[11:0];
    end
    if (o_conv_start === 1'b1) begin
      cnt <= 20;
      ch_r <= o_conv_chan;
    end else if (cnt > 0) cnt <= cnt - 1;
  end
  // ------------------------------------------------------------
  // port tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic hop(logic [7:0] c);
    wr(HREG_CMD, c);
    for (int k = 0; k < 4000 && (k < 2 || o_busy !== 1'b0); k++) begin
      @(posedge i_clk);
      #1;
    end
    if (o_busy !== 1'b0) begin
      n_fail++;
      stop_test();
    end
  endtask : hop
  task automatic wb(logic [7:0] d);
    wr(HREG_DATA, d);
    hop(8'h04);
  endtask : wb
  task automatic rb(logic nk);
    hop(nk ? 8'h18 : 8'h08);
    @(posedge i_clk);
    i_addr <= HREG_DATA;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 b = o_rdata;
  endtask : rb
  task automatic hdr(logic [7:0] p);
    hop(8'h01);
    wb(8'hC2);
    wb(p);
  endtask : hdr
  task automatic rreg(logic [7:0] p);
    hdr(p);
    hop(8'h01);
    wb(8'hC3);
    rb(1'b1);
    hop(8'h02);
  endtask : rreg
  task automatic wst(output int c);
    c = 0;
    do begin
      @(posedge i_clk);
      #1 c++;
    end while (o_conv_start !== 1'b1 && c < 4000);
    if (c >= 4000) begin
      n_fail++;
      stop_test();
    end
  endtask : wst
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk("auto off", 1'b0, o_auto_active);
    hdr(PTR_CMD);
    wb(8'h13);
    chk("cmd mode", 1'b1, o_cmd_mode);
    // status port: ack seen from the command byte, engine idle
    @(posedge i_clk) i_addr <= HREG_STAT;
    i_rd <= 1'b1;
    @(posedge i_clk) i_rd <= 1'b0;
    #1 chk("cmd ack", 16'h0002, o_rdata);
    wb(PTR_RESULT);
    hop(8'h01);
    wb(8'hC3);
    // expected channels: ascending, then wrap to the first
    for (int i = 0; i < 8; i++) begin
      rb(i == 7);
      n = (i < 2) ? 0 : (i < 4) ? 1 : (i < 6) ? 4 : 0;
      chk("result", i[0] ? {8'h00, last_d[n][7:0]} :
        {8'h00, 1'b0, n[2:0], last_d[n][11:8]}, b);
    end
    hop(8'h02);
    repeat (4) @(posedge i_clk);
    #1 chk("cmd exit", 1'b0, o_cmd_mode);
    hdr(PTR_CMD);
    wb(8'h01);
    repeat (1800) @(posedge i_clk);
    #1 chk("cmd held", 1'b1, o_cmd_mode);
    repeat (400) @(posedge i_clk);
    #1 chk("cmd timeout", 1'b0, o_cmd_mode);
    hop(8'h02);
    @(posedge i_clk) i_ovr <= 2'h1;
    @(posedge i_clk) i_ovr <= 2'h2;
    @(posedge i_clk) i_ovr <= 2'h0;
    rreg(PTR_ALERT_I);
    chk("cur status", 16'h0030, b);
    hdr(PTR_ALERT_I);
    wb(8'h10);
    hop(8'h02);
    rreg(PTR_ALERT_I);
    chk("cur clear one", 16'h0020, b);
    @(posedge i_clk) i_otemp <= 1'b1;
    i_diode <= 1'b1;
    @(posedge i_clk) i_otemp <= 1'b0;
    i_diode <= 1'b0;
    rreg(PTR_ALERT_T);
    chk("temp status", 16'h00C0, b);
    chk("dac hiz", 1'b1, o_dac_hiz);
    chk("alert off", 1'b0, o_alert);
    // sequence, then config with autocycle and clear-all in one frame
    hdr(PTR_SEQ);
    wb(8'h01);
    wb(PTR_CFG);
    wb(8'h10);
    wb(8'h06);
    hop(8'h02);
    chk("auto on", 1'b1, o_auto_active);
    rreg(PTR_ALERT_T);
    chk("clear all", 16'h0000, b);
    @(posedge i_clk) i_diode <= 1'b1;
    @(posedge i_clk) i_diode <= 1'b0;
    // the alert register lags the status bit by one clock
    @(posedge i_clk) hi <= 1'b1;
    #1 chk("alert on", 1'b1, o_alert);
    wst(n);
    wst(n);
    chk("auto chan", 3'h0, o_conv_chan);
    chk("auto period", 1'b1, n > AUTO_CYC - 40 && n < AUTO_CYC + 40);
    rreg(PTR_ALERT_V);
    chk("volt status", 16'h0002, b);
    stop_test();
  end
endmodule : tb
